// *** logic/pss_sram_port.sv ***
// pss_sram_port: pipelined synchronous static ram with late write and burst counter
// assumes the controller holds burst_order_select static; data pins split in/out/oe
// Functional notes
// - address, data and synchronous controls are captured on rising mclk
// - load/step low loads a new address, high uses the next burst address
// - two low address bits seed the burst counter; upper bits stay fixed
// - sampling gate high freezes every register and pipeline stage
// - burst order low steps linearly, high interleaved, used unlatched
// - byte selects enable lanes only with a write strobe; no read effect
// - a write updates only selected lanes, others keep their contents
// - selected only when primary enable low, depth high high, depth low low
// - writes start on a rising edge with an internally made write pulse
// - read data goes through an output register, one extra stage
// - output enable gates the data drivers combinationally
// - organised as 128k x 36 with four lanes or 256k x 18 with two
// - read after write and write after read run back to back, no idle
// - byte selects for a starting write are taken only at its load
// - during a burst step only gate, byte selects and load/step count
// - a burst write step with no byte selected still advances the counter
// - a new write with no byte selected still loads the address
`timescale 1ns/1ps
module pss_sram_port #(
  parameter int DATA_W = pss_pkg::PSS_WIDE_DATA_W,
  parameter int LANES = pss_pkg::PSS_WIDE_LANES,
  parameter int ADDR_W = pss_pkg::PSS_WIDE_ADDR_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // address and synchronous controls
  input wire logic [ADDR_W-1:0] sync_address_inputs,
  input wire logic burst_load_step_n,
  input wire logic sampling_gate_n,
  input wire logic primary_chip_enable_n,
  input wire logic depth_enable_high,
  input wire logic depth_enable_low,
  input wire logic write_strobe_n,
  input wire logic [LANES-1:0] byte_write_selects_n,
  // static and asynchronous controls
  input wire logic burst_order_select,
  input wire logic async_output_enable_n,
  // shared data lanes, split into three signals
  input wire logic [DATA_W-1:0] data_lanes_in,
  output logic [DATA_W-1:0] data_lanes_out,
  output logic data_lanes_oe
);
  import pss_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;
  localparam int UP_W = ADDR_W - PSS_SEED_W;

  ////////////////////////////////////////////////////////////////////////////
  // input decode
  logic ce;
  logic sel;
  logic load;
  assign ce = ~sampling_gate_n;
  assign sel = ~primary_chip_enable_n & depth_enable_high & ~depth_enable_low;
  assign load = ~burst_load_step_n;

  // burst state: fixed upper bits, seed, step count, operation of the burst
  logic [UP_W-1:0] base_q;
  logic [1:0] seed_q;
  logic [1:0] cnt_q;
  pss_op_e burst_op_q;
  // stage 1: command just taken; stage 2: command one edge older
  pss_op_e op1_q;
  pss_op_e op2_q;
  logic [ADDR_W-1:0] addr1_q;
  logic [ADDR_W-1:0] addr2_q;
  logic [LANES-1:0] bsel1_q;
  logic [LANES-1:0] bsel2_q;
  logic [DATA_W-1:0] out_q;
  logic oe_q;
  logic [1:0] step_d;
  logic [1:0] nxt_low_d;

  // next burst address; the order pin is read live, so a toggle mid burst
  // would scramble the sequence
  assign step_d = cnt_q + PSS_CNT_STEP;
  assign nxt_low_d = burst_order_select ? (seed_q ^ step_d)
                                        : (seed_q + step_d);

  ////////////////////////////////////////////////////////////////////////////
  // burst counter: load on load/step low, advance otherwise
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      base_q <= '0;
      seed_q <= PSS_CNT_RST;
      cnt_q <= PSS_CNT_RST;
      burst_op_q <= PSS_OP_IDLE;
    end else if (ce) begin
      if (load) begin
        base_q <= sync_address_inputs[ADDR_W-1:PSS_SEED_W];
        seed_q <= sync_address_inputs[PSS_SEED_LSB +: PSS_SEED_W];
        cnt_q <= PSS_CNT_RST;
        if (!sel)
          burst_op_q <= PSS_OP_IDLE;
        else if (!write_strobe_n)
          burst_op_q <= PSS_OP_WRITE;
        else
          burst_op_q <= PSS_OP_READ;
      end else begin
        cnt_q <= step_d;
      end
    end
  end

  // stage 1: enables and strobe only matter on a load cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      op1_q <= PSS_OP_IDLE;
      addr1_q <= '0;
      bsel1_q <= '0;
    end else if (ce) begin
      if (load) begin
        addr1_q <= sync_address_inputs;
        if (!sel) begin
          op1_q <= PSS_OP_IDLE;
          bsel1_q <= '0;
        end else if (!write_strobe_n) begin
          op1_q <= PSS_OP_WRITE;
          bsel1_q <= ~byte_write_selects_n;
        end else begin
          op1_q <= PSS_OP_READ;
          bsel1_q <= '0;
        end
      end else begin
        // burst step: chip enables and strobe are not looked at here
        op1_q <= burst_op_q;
        addr1_q <= {base_q, nxt_low_d};
        bsel1_q <= (burst_op_q == PSS_OP_WRITE) ? ~byte_write_selects_n : '0;
      end
    end
  end

  // stage 2: write data arrives on the edge that retires this stage
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      op2_q <= PSS_OP_IDLE;
      addr2_q <= '0;
      bsel2_q <= '0;
    end else if (ce) begin
      op2_q <= op1_q;
      addr2_q <= addr1_q;
      bsel2_q <= bsel1_q;
    end
  end

  // output register drive flag; only reads turn the drivers on. it follows
  // stage 2 so read data and write data share one latency, which is what
  // lets reads and writes alternate on every edge without an idle cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      oe_q <= 1'b0;
    else if (ce)
      oe_q <= (op2_q == PSS_OP_READ);
  end

  ////////////////////////////////////////////////////////////////////////////
  // array, one bank per lane so each lane writes on its own
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [PSS_LANE_W-1:0] mem [DEPTH];
    logic [PSS_LANE_W-1:0] din;
    assign din = data_lanes_in[l*PSS_LANE_W +: PSS_LANE_W];
    // reads and writes both retire in stage 2, so a read right behind a
    // write to the same word finds the stored byte without any forwarding

    // self timed write: the edge itself is the write pulse
    always_ff @(posedge mclk) begin
      if (ce && op2_q == PSS_OP_WRITE && bsel2_q[l])
        mem[addr2_q] <= din;
    end

    // read into the output register; no reset on the array path
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
        out_q[l*PSS_LANE_W +: PSS_LANE_W] <= '0;
      else if (ce && op2_q == PSS_OP_READ)
        out_q[l*PSS_LANE_W +: PSS_LANE_W] <= mem[addr2_q];
    end

    // a selected lane of a retiring write holds the lane data after the edge
    chk_lane_stored: assert property (@(posedge mclk) disable iff (!nrst)
      ce && op2_q == PSS_OP_WRITE && bsel2_q[l] |=> mem[$past(addr2_q)] == $past(din))
      else $error("selected lane not written");
  end

  assign data_lanes_out = out_q;
  // drivers follow the async enable with no clock in the path
  assign data_lanes_oe = oe_q & ~async_output_enable_n;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_load_read;
    ce && load && sel && write_strobe_n;
  endsequence
  sequence s_load_write;
    ce && load && sel && !write_strobe_n;
  endsequence
  sequence s_step(logic ord);
    ce && !load && (burst_order_select == ord);
  endsequence
  sequence s_write_retire;
    ce && op2_q == PSS_OP_WRITE;
  endsequence
  sequence s_read_retire;
    ce && op2_q == PSS_OP_READ;
  endsequence

  // pipeline timing: a command loaded at edge n reaches stage 1 at n, stage 2
  // at n+1 and retires at n+2; a read then stands on the lanes until n+3,
  // while a write takes its lane data at n+2. gated edges do not count.
  chk_read_pipe: assert property (s_load_read ##1 ce ##1 ce |=> oe_q)
    else $error("read did not reach output register after three edges");
  chk_hold_gate: assert property (!ce |=> $stable(op1_q) && $stable(op2_q)
    && $stable(cnt_q) && $stable(out_q) && $stable(oe_q))
    else $error("state changed while sampling gate high");
  chk_seed_load: assert property (ce && load |=> seed_q == $past(sync_address_inputs[1:0])
    && cnt_q == PSS_CNT_RST && addr1_q == $past(sync_address_inputs))
    else $error("burst seed not loaded");
  chk_linear_step: assert property ((ce && load ##1 s_step(1'b0))
    |=> addr1_q[1:0] == $past(sync_address_inputs[1:0], 2) + 2'h1)
    else $error("linear burst step wrong");
  chk_inter_step: assert property ((ce && load ##1 s_step(1'b1))
    |=> addr1_q[1:0] == ($past(sync_address_inputs[1:0], 2) ^ 2'h1))
    else $error("interleaved burst step wrong");
  chk_upper_fixed: assert property (ce && !load |=> addr1_q[ADDR_W-1:2] == $past(base_q))
    else $error("upper address moved during burst");
  chk_deselect_idle: assert property (ce && load && !sel |=> op1_q == PSS_OP_IDLE)
    else $error("deselected load started an operation");
  chk_read_nobyte: assert property (s_load_read |=> bsel1_q == '0)
    else $error("byte selects active on a read");
  chk_burst_ignore: assert property (ce && !load |=> op1_q == $past(burst_op_q))
    else $error("burst step took new command");
  chk_empty_advance: assert property (ce && !load && burst_op_q == PSS_OP_WRITE
    && (&byte_write_selects_n) |=> bsel1_q == '0 && cnt_q == $past(cnt_q) + 2'h1)
    else $error("empty burst write did not advance");
  chk_write_load: assert property (s_load_write |=> op1_q == PSS_OP_WRITE
    && addr1_q == $past(sync_address_inputs))
    else $error("write load lost its address");
  chk_turnaround: assert property (s_load_write ##1 s_load_read ##1 ce ##1 ce
    |=> oe_q && $past(op2_q) == PSS_OP_READ)
    else $error("read after write needed an idle cycle");
  chk_oe_async: assert property (async_output_enable_n |-> !data_lanes_oe)
    else $error("drivers on with output enable off");

  ////////////////////////////////////////////////////////////////////////////
  // stage checks: each command moves one stage per active edge

  // the drive flag mirrors the stage that retired on the last active edge
  chk_oe_follow: assert property (ce
    |=> oe_q == ($past(op2_q) == PSS_OP_READ))
    else $error("drive flag does not follow the retiring stage");

  // a loaded write is in stage 2 one active edge later
  chk_write_pipe: assert property (s_load_write ##1 ce
    |=> op2_q == PSS_OP_WRITE)
    else $error("write did not reach stage 2");

  // a loaded read is in stage 2 one active edge later
  chk_read_stage: assert property (s_load_read ##1 ce
    |=> op2_q == PSS_OP_READ)
    else $error("read did not reach stage 2");

  // lane selects of a new write are the ones present at its load
  chk_bsel_load: assert property (s_load_write
    |=> bsel1_q == ~$past(byte_write_selects_n))
    else $error("write lane selects not taken at load");

  // a retiring write never turns the drivers on
  chk_write_dark: assert property (s_write_retire |=> !oe_q)
    else $error("drivers on after a write");

  // a retiring read always sets the drive flag; the drivers also need the async enable low
  chk_read_oe: assert property (s_read_retire |=> oe_q)
    else $error("drivers off after a read");

  // a deselected load keeps the drivers off when its slot comes out
  chk_deselect_dark: assert property (ce && load && !sel ##1 ce ##1 ce
    |=> !oe_q)
    else $error("deselected load drove the lanes");

  // a read burst step keeps every lane select clear, whatever the pins say
  chk_step_noread: assert property (ce && !load && burst_op_q == PSS_OP_READ
    |=> bsel1_q == '0)
    else $error("read burst step took lane selects");

  ////////////////////////////////////////////////////////////////////////////
  // burst order checks: second and third steps of a burst

  // linear order: second step is seed plus two
  chk_linear_two: assert property ((ce && load ##1 s_step(1'b0) ##1 s_step(1'b0))
    |=> addr1_q[1:0] == $past(sync_address_inputs[1:0], 3) + 2'h2)
    else $error("linear second step wrong");

  // linear order: third step is seed plus three
  chk_linear_three: assert property ((ce && load ##1 s_step(1'b0) ##1 s_step(1'b0)
    ##1 s_step(1'b0)) |=> addr1_q[1:0] == $past(sync_address_inputs[1:0], 4) + 2'h3)
    else $error("linear third step wrong");

  // interleaved order: second step flips bit one of the seed
  chk_inter_two: assert property ((ce && load ##1 s_step(1'b1) ##1 s_step(1'b1))
    |=> addr1_q[1:0] == ($past(sync_address_inputs[1:0], 3) ^ 2'h2))
    else $error("interleaved second step wrong");

  // interleaved order: third step flips both seed bits
  chk_inter_three: assert property ((ce && load ##1 s_step(1'b1) ##1 s_step(1'b1)
    ##1 s_step(1'b1)) |=> addr1_q[1:0] == ($past(sync_address_inputs[1:0], 4) ^ 2'h3))
    else $error("interleaved third step wrong");
endmodule // pss_sram_port

// *** pkg/pss_pkg.sv ***
// pss_pkg: shared constants and types for the pipelined synchronous sram port
// assumes one clock domain; no register bus, all control arrives on pins
package pss_pkg;
  // wide organisation: 128k words of 36 bits, four lanes
  localparam int PSS_WIDE_DATA_W = 36;
  localparam int PSS_WIDE_LANES = 4;
  localparam int PSS_WIDE_ADDR_W = 17;
  // narrow organisation: 256k words of 18 bits, two lanes
  localparam int PSS_NARROW_DATA_W = 18;
  localparam int PSS_NARROW_LANES = 2;
  localparam int PSS_NARROW_ADDR_W = 18;
  // one byte lane carries nine bits
  localparam int PSS_LANE_W = 9;
  // burst counter: seed position and width
  localparam int PSS_SEED_LSB = 0;
  localparam int PSS_SEED_W = 2;
  localparam logic [1:0] PSS_CNT_RST = 2'h0;
  localparam logic [1:0] PSS_CNT_STEP = 2'h1;
  // pipeline operation codes
  typedef enum logic [1:0] {PSS_OP_IDLE, PSS_OP_READ, PSS_OP_WRITE} pss_op_e;
endpackage

// *** tb/pss_ctrl_model.sv ***
// pss_ctrl_model: controller side of the shared data lanes
// assumes the bench counts active edges and queues each write beat
`timescale 1ns/1ps
module pss_ctrl_model (
  // clock and active edge count
  input wire logic mclk,
  input wire logic [31:0] cyc,
  // write data toward the ram
  output logic [35:0] data_lanes_in
);
  typedef struct {logic [31:0] due; logic [35:0] d;} pss_wr_s;
  pss_wr_s wq[$];
  task automatic push(input logic [31:0] due, input logic [35:0] d);
    wq.push_back('{due, d});
  endtask
  initial data_lanes_in = 36'h0;
  // a beat stands two active edges after its command; otherwise the lanes
  // toggle, so a stale value can never pass for fresh write data
  always @(negedge mclk) begin
    while (wq.size() != 0 && wq[0].due < cyc) void'(wq.pop_front());
    if (wq.size() != 0 && wq[0].due == cyc) data_lanes_in <= wq[0].d;
    else data_lanes_in <= ~data_lanes_in;
  end
endmodule // pss_ctrl_model

// *** tb/pss_sram_port_tb.sv ***
// pss_sram_port_tb: self-checking bench for the sram port, wide organisation
// assumes pss_ctrl_model supplies write data; inputs change on falling mclk
`timescale 1ns/1ps
module pss_sram_port_tb;
  import pss_pkg::*;
  typedef struct {logic [31:0] due; logic rd; logic [35:0] d; logic oe;} pss_exp_s;
  logic mclk, nrst, load_n, gate_n, wr_n, order, aoe_n, oe;
  logic [2:0] en;
  logic [16:0] addr;
  logic [3:0] bsel_n;
  logic [35:0] din, dout;
  logic [31:0] cyc;
  logic [1:0] ser;
  int n_errors, num_checks;
  logic [35:0] mem [int];
  pss_exp_s expq[$];
  pss_sram_port u_dut (.mclk(mclk), .nrst(nrst), .sync_address_inputs(addr),
    .burst_load_step_n(load_n), .sampling_gate_n(gate_n), .primary_chip_enable_n(en[2]),
    .depth_enable_high(en[1]), .depth_enable_low(en[0]), .write_strobe_n(wr_n),
    .byte_write_selects_n(bsel_n), .burst_order_select(order),
    .async_output_enable_n(aoe_n), .data_lanes_in(din), .data_lanes_out(dout),
    .data_lanes_oe(oe));
  pss_ctrl_model u_ctrl (.mclk(mclk), .cyc(cyc), .data_lanes_in(din));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // gated edges must not move the expected pipeline
  always @(posedge mclk) if (nrst && !gate_n) cyc <= cyc + 32'h1;
  ////////////////////////////////////////
  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // compare outputs on the cycle they are due
  always @(negedge mclk) while (expq.size() != 0 && expq[0].due == cyc) begin
    if (expq[0].rd) check(dout, expq[0].d);
    check({35'h0, oe}, {35'h0, expq[0].oe});
    void'(expq.pop_front());
  end
  function automatic logic [16:0] baddr(input logic [16:0] a, input int k);
    logic [1:0] s;
    s = order ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0];
    return {a[16:2], s};
  endfunction
  // steps drive false enables, a flipped strobe and a wrong address on purpose
  task automatic burst(input logic wr, input logic [2:0] e, input logic [16:0] a,
                       input logic [15:0] bs, input int n);
    logic [35:0] d;
    logic [16:0] b;
    ser = ser + 2'h1;
    for (int k = 0; k < n; k++) begin
      @(negedge mclk);
      load_n = (k != 0);
      en = (k != 0) ? 3'h5 : e;
      wr_n = (k != 0) ? wr : !wr;
      addr = (k != 0) ? ~a : a;
      bsel_n = bs[4*k+:4];
      b = baddr(a, k);
      d = {4{ser, b[6:0]}};
      if (e == 3'h2 && wr) begin
        u_ctrl.push(cyc + 32'h2, d);
        for (int l = 0; l < 4; l++) if (!bs[4*k+l]) mem[int'(b)][9*l+:9] = d[9*l+:9];
      end
      expq.push_back('{cyc + 32'h3, e == 3'h2 && !wr, mem[int'(b)], e == 3'h2 && !wr});
    end
  endtask
  task automatic t_back_to_back;
    burst(1'b1, 3'h2, 17'h00102, 16'h0, 4);
    burst(1'b0, 3'h2, 17'h00102, 16'h0, 4);
    burst(1'b1, 3'h2, 17'h00000, 16'h0, 1);
    burst(1'b0, 3'h2, 17'h00000, 16'h0, 1);
  endtask
  task automatic t_lanes;
    burst(1'b1, 3'h2, 17'h00101, 16'hAF0F, 4);
    burst(1'b0, 3'h2, 17'h00101, 16'h0, 4);
  endtask
  task automatic t_deselect;
    logic [2:0] tbl [3] = '{3'h6, 3'h0, 3'h3};
    for (int i = 0; i < 3; i++) begin
      burst(1'b1, tbl[i], 17'h00100, 16'h0, 2);
      burst(1'b0, tbl[i], 17'h00100, 16'h0, 1);
    end
    burst(1'b0, 3'h2, 17'h00100, 16'h0, 4);
  endtask
  task automatic t_order;
    order = 1'b1;
    burst(1'b0, 3'h2, 17'h00101, 16'h0, 4);
    burst(1'b0, 3'h0, 17'h0, 16'h0, 3);
    order = 1'b0;
  endtask
  task automatic t_gate;
    burst(1'b0, 3'h2, 17'h00103, 16'h0, 1);
    burst(1'b0, 3'h0, 17'h0, 16'h0, 2);
    @(negedge mclk);
    gate_n = 1'b1;
    repeat (3) @(negedge mclk) check(dout, mem[32'h103]);
    check({35'h0, oe}, 36'h1);
    aoe_n = 1'b1;
    #1 check({35'h0, oe}, 36'h0);
    aoe_n = 1'b0;
    gate_n = 1'b0;
  endtask
  task automatic give_verdict;
    $display("errors=%0d checks=%0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    load_n = 1'b1;
    gate_n = 1'b0;
    wr_n = 1'b1;
    order = 1'b0;
    aoe_n = 1'b0;
    en = 3'h5;
    addr = 17'h0;
    bsel_n = 4'hF;
    cyc = 32'h0;
    ser = 2'h0;
    repeat (4) @(negedge mclk);
    nrst = 1'b1;
    t_back_to_back();
    t_lanes();
    t_deselect();
    t_order();
    t_gate();
    burst(1'b0, 3'h0, 17'h0, 16'h0, 4);
    // let the last queued slots come out before judging
    repeat (5) @(negedge mclk);
    give_verdict();
  end
  // the whole run needs about 60 cycles
  initial begin
    repeat (1000) @(posedge mclk);
    n_errors++;
    give_verdict();
  end
endmodule // pss_sram_port_tb
